// File: design/ccrb_top.sv
// cache control register bank with dma weight arbiter and queue limits
// Overview of operation
// - weight zero: data cache always wins, dma never gets priority
// - weight one: pending dma wins after sixteen data-cache priority cycles
// - weight two: pending dma wins after four data-cache priority cycles
// - weight three: pending dma wins after one data-cache priority cycle
// - weight is two low bits, bounds data-cache blocking, resets to one
// - upper weight bits read zero, writes to them are discarded
// - four three-bit limits on outstanding requests per dma priority level
// - level stalls new requests while outstanding count is not below limit
// - level zero limit resets to six, levels one to three to two
// - second-level flush: 32-bit base, 16-bit count, both reset zero
// - second-level flush-invalidate: 32-bit base, 16-bit count, reset zero
// - second-level invalidate: 32-bit base, 16-bit count, reset zero
// - program-cache invalidate: 32-bit base, 16-bit count, reset zero
// - data-cache flush-invalidate: 32-bit base, 16-bit count, reset zero
// - data-cache invalidate: 32-bit base, 16-bit count, reset zero
// - unused count and limit bits read zero; software writes zeros
// - dma accesses dropped: writes ignored, reads give undefined data
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ccrb_top
  import ccrb_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pdma_source,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // second-level memory arbiter
  input wire logic dcache_req,
  input wire logic dma_req,
  output logic dcache_grant,
  output logic dma_grant,
  // per-level request limiting
  input wire logic [NUM_QUEUES-1:0] queue_issue,
  input wire logic [NUM_QUEUES-1:0] queue_retire,
  output logic [NUM_QUEUES-1:0] queue_stall,
  // block operations
  input wire logic [NUM_OPS-1:0] op_word_done,
  output logic [NUM_OPS-1:0] op_start,
  output logic [NUM_OPS-1:0] op_busy
);

  // ==========================================================
  // decode helpers
  function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
    hits = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic [4:0] hold_limit(input logic [1:0] w);
    case (w)
      WEIGHT_SLOW: hold_limit = HOLD_SLOW;
      WEIGHT_MID: hold_limit = HOLD_MID;
      WEIGHT_FAST: hold_limit = HOLD_FAST;
      default: hold_limit = 5'h00;
    endcase
  endfunction

  // ==========================================================
  // register state
  logic [WEIGHT_W-1:0] weight_q;
  logic [LIMIT_W-1:0] limit_q [NUM_QUEUES];
  logic [31:0] base_q [NUM_OPS];
  logic [COUNT_W-1:0] count_q [NUM_OPS];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // apb decode; no wait state, every answer comes from a flop loaded in the setup cycle
  wire setup_cyc = psel & ~penable;
  wire commit = psel & penable & pready_q;
  // dma-sourced transfers never touch the bank
  wire cpu_wr = commit & pwrite & ~pdma_source;
  wire sel_weight = hits(paddr, OFF_WEIGHT);
  wire [NUM_QUEUES-1:0] sel_limit;
  wire [NUM_OPS-1:0] sel_base;
  wire [NUM_OPS-1:0] sel_count;
  wire [31:0] rd_limit [NUM_QUEUES];
  wire [31:0] rd_op [NUM_OPS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_QUEUES; gi++) begin : g_lim_dec
      assign sel_limit[gi] = hits(paddr, OFF_LIMIT0 + 12'(gi) * OFF_LIMIT_STEP);
      assign rd_limit[gi] = sel_limit[gi] ? {29'h0, limit_q[gi]} : 32'h0;
    end
    for (gi = 0; gi < NUM_OPS; gi++) begin : g_op_dec
      assign sel_base[gi] = hits(paddr, OFF_BASE0 + 12'(gi) * OFF_OP_STEP);
      assign sel_count[gi] = hits(paddr, OFF_COUNT0 + 12'(gi) * OFF_OP_STEP);
      assign rd_op[gi] = (sel_base[gi] ? base_q[gi] : 32'h0) |
                         (sel_count[gi] ? {16'h0, count_q[gi]} : 32'h0);
    end
  endgenerate

  wire mapped = sel_weight | (|sel_limit) | (|sel_base) | (|sel_count);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = sel_weight ? {30'h0, weight_q} : 32'h0;
    for (int i = 0; i < NUM_QUEUES; i++) begin
      rd_mux = rd_mux | rd_limit[i];
    end
    for (int i = 0; i < NUM_OPS; i++) begin
      rd_mux = rd_mux | rd_op[i];
    end
  end

  wire [31:0] rd_data_d = (pdma_source | ~mapped) ? DROP_DATA : rd_mux;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup_cyc;
      pslverr_q <= setup_cyc & ~mapped;
      prdata_q <= setup_cyc ? rd_data_d : prdata_q;
    end
  end

  // ==========================================================
  // weight and limit registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      weight_q <= WEIGHT_RST;
    end else if (cpu_wr && sel_weight) begin
      weight_q <= pwdata[WEIGHT_W-1:0];
    end
  end

  generate
    for (gi = 0; gi < NUM_QUEUES; gi++) begin : g_lim_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          limit_q[gi] <= (gi == 0) ? LIMIT0_RST : LIMITN_RST;
        end else if (cpu_wr && sel_limit[gi]) begin
          limit_q[gi] <= pwdata[LIMIT_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // block operation registers; a nonzero count write launches the operation
  logic [NUM_OPS-1:0] start_q;
  logic [NUM_OPS-1:0] busy_q;

  generate
    for (gi = 0; gi < NUM_OPS; gi++) begin : g_op_reg
      wire wr_cnt = cpu_wr & sel_count[gi];
      // a fresh write outranks a word retiring in the same cycle
      wire [COUNT_W-1:0] cnt_d = wr_cnt ? pwdata[COUNT_W-1:0] :
        (op_word_done[gi] && count_q[gi] != 16'h0) ? count_q[gi] - 16'h1 : count_q[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_q[gi] <= BASE_RST;
          count_q[gi] <= COUNT_RST;
          start_q[gi] <= 1'b0;
          busy_q[gi] <= 1'b0;
        end else begin
          if (cpu_wr && sel_base[gi]) begin
            base_q[gi] <= pwdata;
          end
          count_q[gi] <= cnt_d;
          start_q[gi] <= wr_cnt && pwdata[COUNT_W-1:0] != 16'h0;
          busy_q[gi] <= cnt_d != 16'h0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // second-level arbiter between data cache and dma
  logic [HOLD_W-1:0] hold_q;
  logic dc_grant_q;
  logic dma_grant_q;
  wire [HOLD_W-1:0] hold_lim = hold_limit(weight_q);
  // weight zero never lets dma past a requesting data cache
  wire dma_turn = (weight_q != WEIGHT_NEVER) && (hold_q >= hold_lim);
  wire dma_win = dma_req & (~dcache_req | dma_turn);
  wire dc_win = dcache_req & ~dma_win;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 5'h00;
      dc_grant_q <= 1'b0;
      dma_grant_q <= 1'b0;
    end else begin
      dc_grant_q <= dc_win;
      dma_grant_q <= dma_win;
      if (dma_win) begin
        hold_q <= 5'h00;
      end else if (dc_win && dma_req && hold_q != 5'h1F) begin
        hold_q <= hold_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // outstanding request counters per priority level
  logic [OUTST_W-1:0] outst_q [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] stall_q;

  generate
    for (gi = 0; gi < NUM_QUEUES; gi++) begin : g_queue
      wire take = queue_issue[gi] & ~stall_q[gi];
      wire give = queue_retire[gi] && outst_q[gi] != 4'h0;
      wire [OUTST_W-1:0] outst_d = outst_q[gi] + {3'h0, take} - {3'h0, give};
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          outst_q[gi] <= 4'h0;
          stall_q[gi] <= 1'b0;
        end else begin
          outst_q[gi] <= outst_d;
          stall_q[gi] <= outst_d >= {1'b0, limit_q[gi]};
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dcache_grant = dc_grant_q;
  assign dma_grant = dma_grant_q;
  assign queue_stall = stall_q;
  assign op_start = start_q;
  assign op_busy = busy_q;

  // ==========================================================
  // checks
  sequence s_contend;
    dcache_req && dma_req;
  endsequence

  sequence s_weight_read;
    psel && !penable && !pwrite && !pdma_source && hits(paddr, OFF_WEIGHT);
  endsequence

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_ready_pulse;
    pready ##1 !pready;
  endsequence

  chk_weight_never: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_NEVER) |=> dcache_grant && !dma_grant)
    else $error("dma won while weight was zero");

  chk_weight_slow: assert property (@(posedge pclk) disable iff (!presetn)
    (weight_q == WEIGHT_SLOW) && dcache_req && dma_win |-> hold_q == 5'h10)
    else $error("dma won without sixteen data-cache cycles");

  chk_weight_mid: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_MID && hold_q == 5'h04) |=> dma_grant)
    else $error("dma not served after four data-cache cycles");

  chk_weight_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (weight_q == WEIGHT_FAST && dcache_req && dma_req)[*2] |=> dma_grant || $past(dma_grant))
    else $error("dma not served after one data-cache cycle");

  chk_weight_upper: assert property (@(posedge pclk) disable iff (!presetn)
    s_weight_read |=> prdata[31:2] == 30'h0 && prdata[1:0] == weight_q)
    else $error("weight readback wrong");

  chk_stall_hold: assert property (@(posedge pclk) disable iff (!presetn)
    stall_q[0] && !queue_retire[0] |=> outst_q[0] == $past(outst_q[0]))
    else $error("request taken while level stalled");

  chk_limit_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> limit_q[0] == 3'h6 && limit_q[1] == 3'h2 &&
      limit_q[2] == 3'h2 && limit_q[3] == 3'h2)
    else $error("limit reset values wrong");

  chk_dma_drop: assert property (@(posedge pclk) disable iff (!presetn)
    commit && pwrite && pdma_source |=> weight_q == $past(weight_q) &&
      limit_q[0] == $past(limit_q[0]) && base_q[OP_L2_FLUSH] == $past(base_q[OP_L2_FLUSH]))
    else $error("dma write changed a register");

  chk_op_launch: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_count[OP_L2_FLUSH] && pwdata[15:0] != 16'h0 |=> op_start[OP_L2_FLUSH]
      ##1 !op_start[OP_L2_FLUSH])
    else $error("count write did not start one operation");

  chk_busy_count: assert property (@(posedge pclk) disable iff (!presetn)
    op_busy[OP_DATA_INVAL] == (count_q[OP_DATA_INVAL] != 16'h0))
    else $error("busy disagrees with remaining count");

  // ==========================================================
  // arbiter thresholds, apb responses, register loads and stall levels
  chk_grant_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    !(dcache_grant && dma_grant))
    else $error("both grants high");

  chk_lone_dcache: assert property (@(posedge pclk) disable iff (!presetn)
    dcache_req && !dma_req |=> dcache_grant && !dma_grant)
    else $error("lone data-cache request not granted");

  chk_slow_reach: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_SLOW && hold_q == HOLD_SLOW) |=> dma_grant)
    else $error("dma not served after sixteen data-cache cycles");

  chk_slow_early: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_SLOW && hold_q < HOLD_SLOW) |=> dcache_grant)
    else $error("dma served before sixteen data-cache cycles");

  chk_mid_early: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_MID && hold_q < HOLD_MID) |=> dcache_grant)
    else $error("dma served before four data-cache cycles");

  chk_fast_reach: assert property (@(posedge pclk) disable iff (!presetn)
    s_contend and (weight_q == WEIGHT_FAST && hold_q == HOLD_FAST) |=> dma_grant)
    else $error("dma not served after one data-cache cycle");

  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> s_ready_pulse)
    else $error("pready not a single access-cycle pulse");

  chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup and !mapped |=> pready && pslverr)
    else $error("unmapped access without error");

  chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup and mapped |=> !pslverr)
    else $error("mapped access flagged as error");

  chk_dma_read: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup and (pdma_source && !pwrite) |=> prdata == DROP_DATA)
    else $error("dma read returned register contents");

  chk_count_upper: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup and (|sel_count) |=> prdata[31:16] == 16'h0000)
    else $error("count upper bits not zero");

  chk_limit_upper: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup and (|sel_limit) |=> prdata[31:3] == 29'h0000_0000)
    else $error("limit upper bits not zero");

  chk_weight_load: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_weight |=> weight_q == $past(pwdata[1:0]))
    else $error("weight write lost");

  chk_limit_load: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_limit[2] |=> limit_q[2] == $past(pwdata[2:0]))
    else $error("limit write lost");

  chk_base_load: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_base[OP_L2_FLUSH] |=> base_q[OP_L2_FLUSH] == $past(pwdata))
    else $error("base write lost");

  chk_count_load: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_count[OP_DATA_INVAL] |=> count_q[OP_DATA_INVAL] == $past(pwdata[15:0]))
    else $error("count write lost");

  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    !cpu_wr && op_word_done[OP_L2_INVAL] && count_q[OP_L2_INVAL] != 16'h0 |=>
      count_q[OP_L2_INVAL] == $past(count_q[OP_L2_INVAL]) - 16'h1)
    else $error("count did not step down on a finished word");

  chk_busy_set: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_wr && sel_count[OP_PROG_INVAL] && pwdata[15:0] != 16'h0 |=> op_busy[OP_PROG_INVAL])
    else $error("busy not raised by count write");

  chk_stall_level: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(limit_q[2]) |-> stall_q[2] == (outst_q[2] >= {1'b0, limit_q[2]}))
    else $error("stall disagrees with outstanding count");

  chk_stall_hold3: assert property (@(posedge pclk) disable iff (!presetn)
    stall_q[3] && !queue_retire[3] |=> outst_q[3] == $past(outst_q[3]))
    else $error("request taken while level three stalled");

endmodule
`default_nettype wire

// File: design/ccrb_pkg.sv
// shared constants of the cache control register bank
package ccrb_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_WEIGHT = 12'h000;
  localparam logic [11:0] OFF_LIMIT0 = 12'h010;
  localparam logic [11:0] OFF_LIMIT_STEP = 12'h004;
  localparam logic [11:0] OFF_BASE0 = 12'h020;
  localparam logic [11:0] OFF_COUNT0 = 12'h024;
  localparam logic [11:0] OFF_OP_STEP = 12'h008;
  // ==========================================================
  // sizes and field layout
  localparam int NUM_QUEUES = 4;
  localparam int NUM_OPS = 6;
  localparam int WEIGHT_W = 2;
  localparam int LIMIT_W = 3;
  localparam int COUNT_W = 16;
  localparam int OUTST_W = 4;
  localparam int HOLD_W = 5;
  // ==========================================================
  // reset values
  localparam logic [1:0] WEIGHT_RST = 2'h1;
  localparam logic [2:0] LIMIT0_RST = 3'h6;
  localparam logic [2:0] LIMITN_RST = 3'h2;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // ==========================================================
  // dma weight encodings and hold limits in data-cache cycles
  localparam logic [1:0] WEIGHT_NEVER = 2'h0;
  localparam logic [1:0] WEIGHT_SLOW = 2'h1;
  localparam logic [1:0] WEIGHT_MID = 2'h2;
  localparam logic [1:0] WEIGHT_FAST = 2'h3;
  localparam logic [4:0] HOLD_SLOW = 5'h10;
  localparam logic [4:0] HOLD_MID = 5'h04;
  localparam logic [4:0] HOLD_FAST = 5'h01;
  // ==========================================================
  // block operation indices
  localparam int OP_L2_FLUSH = 0;
  localparam int OP_L2_FLUSH_INVAL = 1;
  localparam int OP_L2_INVAL = 2;
  localparam int OP_PROG_INVAL = 3;
  localparam int OP_DATA_FLUSH_INVAL = 4;
  localparam int OP_DATA_INVAL = 5;
  // answer to a read that is dropped or unmapped
  localparam logic [31:0] DROP_DATA = 32'h0000_0000;
endpackage

// File: dv/ccrb_top_test.sv
// self-checking bench of the cache control register bank
`timescale 1ns/100ps
`default_nettype none
module ccrb_top_test;
  import ccrb_pkg::*;
  // ==========================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pdma_source, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mdl[17];
  logic er, dcache_req, dma_req, dcache_grant, dma_grant, enhanced_dma_controller, edc;
  logic [3:0] queue_issue, queue_retire, queue_stall, stl;
  logic [5:0] op_word_done, op_start, op_busy;
  int mismatches, comparisons, hold, lim, cnt[4];
  ccrb_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pdma_source(pdma_source),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dcache_req(dcache_req),
    .dma_req(dma_req), .dcache_grant(dcache_grant), .dma_grant(dma_grant),
    .queue_issue(queue_issue), .queue_retire(queue_retire), .queue_stall(queue_stall),
    .op_word_done(op_word_done), .op_start(op_start), .op_busy(op_busy));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [11:0] ra(int k);
    if (k == 0) return OFF_WEIGHT;
    if (k < 5) return OFF_LIMIT0 + OFF_LIMIT_STEP * 12'(k - 1);
    return OFF_BASE0 + OFF_OP_STEP * 12'((k - 5) / 2) + (OFF_COUNT0 - OFF_BASE0) * 12'((k - 5) % 2);
  endfunction
  function automatic logic [31:0] rm(int k);
    if (k == 0) return 32'h3;
    if (k < 5) return 32'h7;
    return ((k - 5) % 2) ? 32'hFFFF : 32'hFFFF_FFFF;
  endfunction
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic dm);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pdma_source <= dm;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wr(int k, logic [31:0] d);
    apb(1, ra(k), (k == 0) ? d : d & rm(k), 0);
    mdl[k] = d & rm(k);
  endtask
  task automatic rdc(int k);
    apb(0, ra(k), 32'h0, 0);
    chk($sformatf("reg%0d", k), mdl[k], rd);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, pdma_source, dcache_req, dma_req} = 0;
    {paddr, pwdata, queue_issue, queue_retire, op_word_done} = 0;
    void'($urandom(98879));
    for (int k = 0; k < 17; k++) mdl[k] = (k == 0) ? 32'h1 : (k == 1) ? 32'h6 : (k < 5) ? 32'h2 : 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 17; k++) rdc(k);
    for (int k = 0; k < 17; k++) wr(k, $urandom);
    for (int k = 0; k < 17; k++) rdc(k);
    apb(1, ra(5), ~mdl[5], 1);
    chk("dma_err", 32'h0, {31'h0, er});
    apb(0, ra(5), 32'h0, 1);
    chk("dma_rd", DROP_DATA, rd);
    rdc(5);
    apb(0, 12'h00C, 32'h0, 0);
    chk("unmapped", 32'h1, {31'h0, er});
    // block operations: start, live count, completion
    for (int i = 0; i < NUM_OPS; i++) begin
      wr(6 + 2 * i, 32'h3);
      #1 chk("op_start", 32'h1 << i, {26'h0, op_start});
      chk("op_busy", 32'h1, {31'h0, op_busy[i]});
      @(posedge pclk) op_word_done <= 6'h1 << i;
      @(posedge pclk) op_word_done <= 6'h0;
      mdl[6 + 2 * i] = 32'h2;
      rdc(6 + 2 * i);
      @(posedge pclk) op_word_done <= 6'h1 << i;
      repeat (2) @(posedge pclk);
      op_word_done <= 6'h0;
      mdl[6 + 2 * i] = 32'h0;
      rdc(6 + 2 * i);
      chk("op_idle", 32'h0, {31'h0, op_busy[i]});
    end
    // arbiter and queue limits against a cycle model, random traffic
    for (int q = 0; q < 4; q++) wr(1 + q, q);
    for (int q = 0; q < 4; q++) stl[q] = (cnt[q] >= int'(mdl[1 + q]));
    for (int w = 0; w < 4; w++) begin
      wr(0, w);
      lim = (w == 1) ? 16 : (w == 2) ? 4 : 1;
      for (int c = 0; c < 120; c++) begin
        @(posedge pclk);
        enhanced_dma_controller = dma_req && (!dcache_req || (w != 0 && hold >= lim));
        edc = dcache_req && !enhanced_dma_controller;
        if (enhanced_dma_controller) hold = 0;
        else if (edc && dma_req) hold++;
        for (int q = 0; q < 4; q++) begin
          cnt[q] += (queue_issue[q] && !stl[q]) - queue_retire[q];
          stl[q] = (cnt[q] >= int'(mdl[1 + q]));
        end
        // a forced dma-only start clears the hold count on both sides
        // last cycle drives idle so the model sees no edge it skips
        dcache_req <= (c < 2 || c > 118) ? 1'b0 :
          (w == 1) ? ($urandom % 32 != 0) : ($urandom % 4 != 0);
        dma_req <= (c > 118) ? 1'b0 : (c < 2) ? 1'b1 : 1'($urandom);
        queue_issue <= (c > 118) ? 4'h0 : 4'($urandom);
        for (int q = 0; q < 4; q++) begin
          queue_retire[q] <= (c < 119) && (cnt[q] > 0) && ($urandom % 3 == 0);
        end
        #1 chk("dcache_grant", {31'h0, edc}, {31'h0, dcache_grant});
        chk("dma_grant", {31'h0, enhanced_dma_controller}, {31'h0, dma_grant});
        chk("queue_stall", {28'h0, stl}, {28'h0, queue_stall});
      end
      @(posedge pclk);
      {dcache_req, dma_req, queue_issue, queue_retire} <= 0;
    end
    final_report();
  end
endmodule
`default_nettype wire
